// file: verilog/pads_pkg.sv
// Purpose: shared constants and types of the pin analog/digital select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: only ports A, B and C are covered here
//
// Notes on behaviour
// - select bit 1: analog mode, digital read off
// - select bit 0: digital mode, digital read on
// - implemented select bits read/write, reset to 1
// - unimplemented select bits always read zero
// - digital input valid one cycle after configuring
// - port A implements 15:14, 10:9, 7:4, 1
// - port B implements 15:12 and 7:0
// - port C implements 4:3 and 1
// - 64-pin build drops the flagged select bits
// - direction 1 means input; inputs after reset
// - pin read returns low for analog pins
package pads_pkg;

    // ****************************************************************
    // register offsets (byte addresses on the apb bus)
    // ****************************************************************
    localparam logic [11:0] OFF_ANA_A = 12'h000; // port_a_analog_select
    localparam logic [11:0] OFF_ANA_B = 12'h004; // port_b_analog_select
    localparam logic [11:0] OFF_ANA_C = 12'h008; // port_c_analog_select
    localparam logic [11:0] OFF_DIR_A = 12'h00C; // direction bits, port a
    localparam logic [11:0] OFF_DIR_B = 12'h010; // direction bits, port b
    localparam logic [11:0] OFF_DIR_C = 12'h014; // direction bits, port c
    localparam logic [11:0] OFF_RD_A = 12'h018; // pin_read_register, a
    localparam logic [11:0] OFF_RD_B = 12'h01C; // pin_read_register, b
    localparam logic [11:0] OFF_RD_C = 12'h020; // pin_read_register, c
    localparam logic [11:0] OFF_VIEW_SEL = 12'h024; // port shown by view
    localparam logic [11:0] OFF_VIEW = 12'h028; // per-pin mode view

    // ****************************************************************
    // implemented bit masks, full and 64-pin builds
    // ****************************************************************
    localparam logic [15:0] IMPL_A_FULL = 16'hC6F2;
    localparam logic [15:0] IMPL_B_FULL = 16'hF0FF;
    localparam logic [15:0] IMPL_C_FULL = 16'h001A;
    localparam logic [15:0] IMPL_A_64 = 16'h0000;
    localparam logic [15:0] IMPL_B_64 = 16'hF0FF;
    localparam logic [15:0] IMPL_C_64 = 16'h0000;

    // ****************************************************************
    // reset values and view encoding
    // ****************************************************************
    localparam logic [1:0] VIEW_SEL_RST = 2'h0; // view starts on port a
    localparam logic [1:0] VIEW_SEL_A = 2'h0; // view selects port a
    localparam logic [1:0] VIEW_SEL_B = 2'h1; // view selects port b
    localparam logic [1:0] VIEW_SEL_C = 2'h2; // view selects port c
    localparam int SAMPLE_LAT_CYC = 1; // pin to pin_read_register delay

    // per-pin control lines handed to the pad ring
    typedef struct packed {
        logic [15:0] ana_mode; // pad in analog mode
        logic [15:0] dig_rd_en; // digital input path enabled
        logic [15:0] drv_en; // digital output driver enabled
    } pads_pinctl_t;

endpackage : pads_pkg

// file: verilog/pads_port.sv
// Purpose: select, direction and pin sampling for one 16-pin port
// Assumes: writes arrive as one-cycle strobes with a per-bit lane mask
// Notes: unimplemented positions hold zero and ignore writes
`timescale 1ns/1ns
module pads_port #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    input logic pclk,
    input logic presetn,
    input logic ana_we,
    input logic dir_we,
    input logic [15:0] wr_data,
    input logic [15:0] wr_mask,
    input logic [15:0] pin_in,
    output logic [15:0] ana_q,
    output logic [15:0] dir_q,
    output logic [15:0] pin_rd_q,
    output pads_pkg::pads_pinctl_t pin_ctl
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [15:0] ana_ff; // analog_select_bit per pin
    logic [15:0] dir_ff; // direction_bit per pin
    logic [15:0] rd_ff; // sampled pin levels
    pads_pkg::pads_pinctl_t ctl_ff; // registered pad controls
    logic [15:0] nxt_ana; // select after this edge
    logic [15:0] nxt_dir; // direction after this edge
    logic [15:0] lane; // writable positions of this write

    // only implemented bits can ever change
    assign lane = wr_mask & IMPL_MASK;
    assign nxt_ana = ana_we ? ((ana_ff & ~lane) | (wr_data & lane))
                            : ana_ff;
    assign nxt_dir = dir_we ? ((dir_ff & ~lane) | (wr_data & lane))
                            : dir_ff;

    // select bits come up analog; unimplemented ones reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ana_ff <= IMPL_MASK;
        end else begin
            ana_ff <= nxt_ana;
        end
    end

    // every implemented pin comes up as an input; unimplemented ones reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= IMPL_MASK;
        end else begin
            dir_ff <= nxt_dir;
        end
    end

    // analog pins read low, so the read is masked before sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= 16'h0000;
        end else begin
            rd_ff <= pin_in & ~ana_ff & IMPL_MASK;
        end
    end

    // pad controls follow the next register value, so they change on
    // the same edge as the register that commands them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff.ana_mode <= IMPL_MASK;
            ctl_ff.dig_rd_en <= 16'h0000;
            ctl_ff.drv_en <= 16'h0000;
        end else begin
            ctl_ff.ana_mode <= nxt_ana;
            ctl_ff.dig_rd_en <= ~nxt_ana & IMPL_MASK;
            // analog mode keeps the digital driver off whatever the
            // direction bit says; safer than driving an analog node
            ctl_ff.drv_en <= ~nxt_ana & ~nxt_dir & IMPL_MASK;
        end
    end

    assign ana_q = ana_ff;
    assign dir_q = dir_ff;
    assign pin_rd_q = rd_ff;
    assign pin_ctl = ctl_ff;

endmodule : pads_port

// file: verilog/pads_top.sv
// Purpose: apb slave for the pin analog/digital select of ports a-c
// Assumes: apb with pstrb, 12-bit byte address, 32-bit data
// Notes: one wait-free access phase; unmapped offsets give pslverr
`timescale 1ns/1ns
module pads_top #(
    parameter bit PKG_64PIN = 1'b0
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic [15:0] pin_a_in,
    input logic [15:0] pin_b_in,
    input logic [15:0] pin_c_in,
    output pads_pkg::pads_pinctl_t pin_ctl_a,
    output pads_pkg::pads_pinctl_t pin_ctl_b,
    output pads_pkg::pads_pinctl_t pin_ctl_c
);

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // implemented mask of a port for the chosen package
    function automatic logic [15:0] impl_mask(
        input logic [1:0] port,
        input bit pkg64
    );
        logic [15:0] m;
        m = 16'h0000;
        unique case (port)
            pads_pkg::VIEW_SEL_A: begin
                m = pkg64 ? pads_pkg::IMPL_A_64
                          : pads_pkg::IMPL_A_FULL;
            end
            pads_pkg::VIEW_SEL_B: begin
                m = pkg64 ? pads_pkg::IMPL_B_64
                          : pads_pkg::IMPL_B_FULL;
            end
            pads_pkg::VIEW_SEL_C: begin
                m = pkg64 ? pads_pkg::IMPL_C_64
                          : pads_pkg::IMPL_C_FULL;
            end
            default: begin
                m = 16'h0000;
            end
        endcase
        return m;
    endfunction : impl_mask

    // byte strobes widened to a bit mask over the low half-word
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // two bits per pin: select bit high, direction bit low
    function automatic logic [31:0] mode_view(
        input logic [15:0] ana,
        input logic [15:0] dir
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 16; i++) begin
            w[2*i+1] = ana[i];
            w[2*i] = dir[i];
        end
        return w;
    endfunction : mode_view

    // low half-word zero-extended to the bus width
    function automatic logic [31:0] word16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction : word16

    // ****************************************************************
    // constants fixed at elaboration
    // ****************************************************************
    localparam logic [15:0] MASK_A = impl_mask(pads_pkg::VIEW_SEL_A,
                                               PKG_64PIN);
    localparam logic [15:0] MASK_B = impl_mask(pads_pkg::VIEW_SEL_B,
                                               PKG_64PIN);
    localparam logic [15:0] MASK_C = impl_mask(pads_pkg::VIEW_SEL_C,
                                               PKG_64PIN);

    // ****************************************************************
    // bus state
    // ****************************************************************
    logic pready_ff; // high for exactly the access phase
    logic pslverr_ff; // error answer of the pending transfer
    logic [31:0] prdata_ff; // read answer of the pending transfer
    logic [1:0] view_sel_ff; // port whose modes the view shows
    logic [31:0] nxt_rdata; // read data decoded in the setup phase
    logic nxt_err; // address decoded as unmapped
    logic setup; // setup phase of a transfer
    logic wr_go; // the one edge at which a write lands
    logic [15:0] wmask; // bit lanes of the write

    // per-port values seen by the read path
    logic [15:0] ana_a; // select bits, port a
    logic [15:0] ana_b; // select bits, port b
    logic [15:0] ana_c; // select bits, port c
    logic [15:0] dir_a; // direction bits, port a
    logic [15:0] dir_b; // direction bits, port b
    logic [15:0] dir_c; // direction bits, port c
    logic [15:0] rd_a; // pin read value, port a
    logic [15:0] rd_b; // pin read value, port b
    logic [15:0] rd_c; // pin read value, port c

    // ****************************************************************
    // phase tracking
    // ****************************************************************

    // the answer is prepared during setup, so pready can come from a
    // flop without adding a wait state
    assign setup = psel & ~penable;

    // a write lands only where the master samples pready high
    assign wr_go = psel & penable & pwrite & pready_ff;

    // byte lanes beyond the low half-word carry no register bits
    assign wmask = lane_mask(pstrb);

    // pready rises for the access phase and falls after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else if (setup) begin
            pready_ff <= 1'b1;
        end else begin
            pready_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // read and error decode
    // ****************************************************************

    // misaligned or unknown offsets fall to the default branch
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        unique case (paddr)
            pads_pkg::OFF_ANA_A: begin
                nxt_rdata = word16(ana_a);
            end
            pads_pkg::OFF_ANA_B: begin
                nxt_rdata = word16(ana_b);
            end
            pads_pkg::OFF_ANA_C: begin
                nxt_rdata = word16(ana_c);
            end
            pads_pkg::OFF_DIR_A: begin
                nxt_rdata = word16(dir_a);
            end
            pads_pkg::OFF_DIR_B: begin
                nxt_rdata = word16(dir_b);
            end
            pads_pkg::OFF_DIR_C: begin
                nxt_rdata = word16(dir_c);
            end
            pads_pkg::OFF_RD_A: begin
                nxt_rdata = word16(rd_a);
            end
            pads_pkg::OFF_RD_B: begin
                nxt_rdata = word16(rd_b);
            end
            pads_pkg::OFF_RD_C: begin
                nxt_rdata = word16(rd_c);
            end
            pads_pkg::OFF_VIEW_SEL: begin
                nxt_rdata = {30'h0000_0000, view_sel_ff};
            end
            pads_pkg::OFF_VIEW: begin
                // an out-of-range selection shows all zero
                if (view_sel_ff == pads_pkg::VIEW_SEL_A) begin
                    nxt_rdata = mode_view(ana_a, dir_a);
                end else if (view_sel_ff == pads_pkg::VIEW_SEL_B) begin
                    nxt_rdata = mode_view(ana_b, dir_b);
                end else if (view_sel_ff == pads_pkg::VIEW_SEL_C) begin
                    nxt_rdata = mode_view(ana_c, dir_c);
                end else begin
                    nxt_rdata = 32'h0000_0000;
                end
            end
            default: begin
                nxt_err = 1'b1;
            end
        endcase
    end

    // read data is captured in setup and held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end else if (setup) begin
            // writes return zero so no stale data lingers on the bus
            prdata_ff <= 32'h0000_0000;
        end
    end

    // error answer covers reads and writes alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            pslverr_ff <= nxt_err;
        end else begin
            pslverr_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // mode view selection
    // ****************************************************************

    // byte lane 0 carries the selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            view_sel_ff <= pads_pkg::VIEW_SEL_RST;
        end else if (wr_go && paddr == pads_pkg::OFF_VIEW_SEL
                     && pstrb[0]) begin
            view_sel_ff <= pwdata[1:0];
        end
    end

    // ****************************************************************
    // ports
    // ****************************************************************

    // read-only offsets simply decode no strobe, so writes there fall
    // away without an error and without a side effect
    pads_port #(
        .IMPL_MASK(MASK_A)
    ) u_port_a (
        .pclk(pclk),
        .presetn(presetn),
        .ana_we(wr_go && paddr == pads_pkg::OFF_ANA_A),
        .dir_we(wr_go && paddr == pads_pkg::OFF_DIR_A),
        .wr_data(pwdata[15:0]),
        .wr_mask(wmask),
        .pin_in(pin_a_in),
        .ana_q(ana_a),
        .dir_q(dir_a),
        .pin_rd_q(rd_a),
        .pin_ctl(pin_ctl_a)
    );

    pads_port #(
        .IMPL_MASK(MASK_B)
    ) u_port_b (
        .pclk(pclk),
        .presetn(presetn),
        .ana_we(wr_go && paddr == pads_pkg::OFF_ANA_B),
        .dir_we(wr_go && paddr == pads_pkg::OFF_DIR_B),
        .wr_data(pwdata[15:0]),
        .wr_mask(wmask),
        .pin_in(pin_b_in),
        .ana_q(ana_b),
        .dir_q(dir_b),
        .pin_rd_q(rd_b),
        .pin_ctl(pin_ctl_b)
    );

    pads_port #(
        .IMPL_MASK(MASK_C)
    ) u_port_c (
        .pclk(pclk),
        .presetn(presetn),
        .ana_we(wr_go && paddr == pads_pkg::OFF_ANA_C),
        .dir_we(wr_go && paddr == pads_pkg::OFF_DIR_C),
        .wr_data(pwdata[15:0]),
        .wr_mask(wmask),
        .pin_in(pin_c_in),
        .ana_q(ana_c),
        .dir_q(dir_c),
        .pin_rd_q(rd_c),
        .pin_ctl(pin_ctl_c)
    );

    // ****************************************************************
    // bus outputs, all straight from flops
    // ****************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule : pads_top

// file: verif/pads_pin_model.sv
// Purpose: pins and analog functions outside one 16-pin port
// Assumes: levels come from the bench in step with pclk
// Notes: lines the block drives are released by this model
`timescale 1ns/1ns
module pads_pin_model (
    input logic pclk,
    input logic presetn,
    input logic [15:0] level,
    input logic [15:0] drv_en,
    output logic [15:0] pin
);
    logic [15:0] float_ff; // pattern seen on released lines

    // released lines change every cycle so a stale value never passes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            float_ff <= 16'h5A5A;
        end else begin
            float_ff <= ~float_ff;
        end
    end

    // analog and input pins carry the outside level
    // a pin whose driver is on is left to the block
    assign pin = (level & ~drv_en) | (float_ff & drv_en);
endmodule : pads_pin_model

// file: verif/pads_top_sva.sv
// Purpose: port assertions for the select block
// Assumes: the master keeps the apb setup/access order
// Notes: bound to every instance, 64-pin build included
`timescale 1ns/1ns
module pads_top_sva #(
    parameter bit PKG_64PIN = 1'b0
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input pads_pkg::pads_pinctl_t pin_ctl_a,
    input pads_pkg::pads_pinctl_t pin_ctl_b,
    input pads_pkg::pads_pinctl_t pin_ctl_c
);
    // implemented lanes of this build
    localparam logic [15:0] MA = PKG_64PIN ? pads_pkg::IMPL_A_64 :
        pads_pkg::IMPL_A_FULL;
    localparam logic [15:0] MB = PKG_64PIN ? pads_pkg::IMPL_B_64 :
        pads_pkg::IMPL_B_FULL;
    localparam logic [15:0] MC = PKG_64PIN ? pads_pkg::IMPL_C_64 :
        pads_pkg::IMPL_C_FULL;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // sequences
    // ****************************************************************
    // full-word write of the port a select, setup then access
    sequence s_wr_a;
        psel && !penable && pwrite && paddr == pads_pkg::OFF_ANA_A &&
            pstrb[1:0] == 2'h3 ##1 psel && penable && pready;
    endsequence
    // pin read of port a whose select did not just move
    sequence s_rd_pin_a;
        psel && !penable && !pwrite && paddr == pads_pkg::OFF_RD_A &&
            $stable(pin_ctl_a.ana_mode);
    endsequence

    AST_ACCESS_NEXT: assert property (psel && !penable |=> pready)
        else $error("no ready in the access phase");
    AST_READY_ONE: assert property (pready |->
        psel && penable ##1 !pready)
        else $error("ready outside one access cycle");
    AST_ANA_NO_DIG: assert property (((pin_ctl_a.ana_mode &
        (pin_ctl_a.dig_rd_en | pin_ctl_a.drv_en)) | (pin_ctl_b.ana_mode &
        (pin_ctl_b.dig_rd_en | pin_ctl_b.drv_en))) == 16'h0000)
        else $error("analog pin with digital path on");
    AST_DIG_READ: assert property (pin_ctl_a.dig_rd_en ==
        (~pin_ctl_a.ana_mode & MA) && pin_ctl_c.dig_rd_en ==
        (~pin_ctl_c.ana_mode & MC))
        else $error("digital read path does not follow select");
    AST_RST_ANALOG: assert property ($rose(presetn) |->
        pin_ctl_a.ana_mode == MA && pin_ctl_b.ana_mode == MB &&
        pin_ctl_c.ana_mode == MC && pin_ctl_b.drv_en == 16'h0000)
        else $error("pins not analog inputs after reset");
    AST_UNIMPL: assert property (
        ((pin_ctl_a.ana_mode & ~MA) | (pin_ctl_b.ana_mode & ~MB) |
        (pin_ctl_c.ana_mode & ~MC)) == 16'h0000)
        else $error("unimplemented select bit set");
    AST_WR_A: assert property (s_wr_a |=>
        pin_ctl_a.ana_mode == ($past(pwdata[15:0]) & MA))
        else $error("select write not taken on implemented lanes");
    AST_PIN_LOW: assert property (s_rd_pin_a |=>
        (prdata[15:0] & pin_ctl_a.ana_mode) == 16'h0000)
        else $error("analog pin reads high");
    AST_UPPER_ZERO: assert property (pready && !pwrite &&
        paddr != pads_pkg::OFF_VIEW |-> prdata[31:16] == 16'h0000)
        else $error("upper half of a register read not zero");
endmodule : pads_top_sva

bind pads_top pads_top_sva #(.PKG_64PIN(PKG_64PIN)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_ctl_a(pin_ctl_a), .pin_ctl_b(pin_ctl_b), .pin_ctl_c(pin_ctl_c)
);

// file: verif/testbench.sv
// Purpose: self-checking bench of the select block
// Assumes: apb master in this file, pin models per port
// Notes: a 64-pin instance shares the bus and is watched too
`timescale 1ns/1ns
module testbench;
    logic pclk, presetn, psel, penable, pwrite, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [3:0] pstrb, st;
    logic pready, pslverr;
    logic [15:0] lvl [3], pin [3], msk [3], m64 [3], ana [3], dir [3], ln;
    pads_pkg::pads_pinctl_t ctl [3], c64 [3];
    int err_total, checks, p, wd, q;

    pads_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_a_in(pin[0]), .pin_b_in(pin[1]), .pin_c_in(pin[2]),
        .pin_ctl_a(ctl[0]), .pin_ctl_b(ctl[1]), .pin_ctl_c(ctl[2]));
    // reduced build sees the same bus; the bench judges only its ana_mode lines
    pads_top #(.PKG_64PIN(1'b1)) uut64 (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
        .pin_a_in(pin[0]), .pin_b_in(pin[1]), .pin_c_in(pin[2]),
        .pin_ctl_a(c64[0]), .pin_ctl_b(c64[1]), .pin_ctl_c(c64[2]));
    for (genvar g = 0; g < 3; g++) begin : g_pins
        pads_pin_model m (.pclk(pclk), .presetn(presetn), .level(lvl[g]),
            .drv_en(ctl[g].drv_en), .pin(pin[g]));
    end

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one transfer; psel stays up so a next setup may follow at once
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wv, input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wv;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            err_total++;
            summarize();
        end
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF);
        check(48'(rd), 48'(e));
        check(48'(er), 48'h0);
    endtask : rdchk

    // ****************************************************************
    // expectations
    // ****************************************************************
    function automatic logic [11:0] adr(input logic [11:0] b, input int k);
        return b + 12'(4 * k);
    endfunction : adr

    // analog forces both digital paths off; output needs direction 0
    function automatic logic [47:0] exp_ctl(input int k);
        return {ana[k], ~ana[k] & msk[k], ~ana[k] & ~dir[k] & msk[k]};
    endfunction : exp_ctl

    function automatic logic [15:0] upd(input logic [15:0] o);
        return (o & ~ln) | (d[15:0] & ln);
    endfunction : upd

    function automatic logic [31:0] view(input int k);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 16; i++) begin
            if (k < 3) begin
                v[2 * i + 1] = ana[k][i];
                v[2 * i] = dir[k][i];
            end
        end
        return v;
    endfunction : view

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        lvl = '{16'h0000, 16'h0000, 16'h0000};
        err_total = 0;
        checks = 0;
        msk = '{pads_pkg::IMPL_A_FULL, pads_pkg::IMPL_B_FULL,
            pads_pkg::IMPL_C_FULL};
        m64 = '{pads_pkg::IMPL_A_64, pads_pkg::IMPL_B_64,
            pads_pkg::IMPL_C_64};
        ana = msk;
        dir = msk;
        void'($urandom(32054));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, then all-zero and all-ones writes
        for (int k = 0; k < 3; k++) begin
            check(ctl[k], exp_ctl(k));
            check(48'(c64[k].ana_mode), 48'(m64[k]));
            rdchk(adr(pads_pkg::OFF_ANA_A, k), 32'(msk[k]));
            rdchk(adr(pads_pkg::OFF_DIR_A, k), 32'(msk[k]));
            for (int v = 0; v < 2; v++) begin
                apb(1'b1, adr(pads_pkg::OFF_ANA_A, k), {32{v[0]}}, 4'hF);
                apb(1'b1, adr(pads_pkg::OFF_DIR_A, k), {32{v[0]}}, 4'hF);
                ana[k] = {16{v[0]}} & msk[k];
                dir[k] = ana[k];
                rdchk(adr(pads_pkg::OFF_ANA_A, k),
                    32'(ana[k]));
                check(ctl[k], exp_ctl(k));
                check(48'(c64[k].ana_mode), 48'(ana[k] & m64[k]));
            end
        end
        // unmapped, misaligned and read-only places
        apb(1'b0, 12'h02C, 32'h0, 4'hF);
        check(48'({er, rd}), 48'h1_0000_0000);
        apb(1'b1, 12'h006, 32'hFFFF_FFFF, 4'hF);
        check(48'(er), 48'h1);
        apb(1'b1, pads_pkg::OFF_RD_B, 32'hFFFF_FFFF, 4'hF);
        check(48'(er), 48'h0);
        rdchk(pads_pkg::OFF_ANA_B, 32'(ana[1]));
        // random lane writes, pin levels and mode views
        for (int i = 0; i < 40; i++) begin
            p = $urandom_range(2);
            d = $urandom;
            st = 4'($urandom);
            wd = $urandom_range(1);
            ln = {{8{st[1]}}, {8{st[0]}}} & msk[p];
            apb(1'b1, adr(wd ? pads_pkg::OFF_DIR_A : pads_pkg::OFF_ANA_A, p),
                d, st);
            if (wd != 0) begin
                dir[p] = upd(dir[p]);
            end else begin
                ana[p] = upd(ana[p]);
            end
            lvl[p] <= 16'($urandom);
            rdchk(adr(pads_pkg::OFF_ANA_A, p), 32'(ana[p]));
            rdchk(adr(pads_pkg::OFF_DIR_A, p), 32'(dir[p]));
            check(ctl[p], exp_ctl(p));
            // only input and analog pins hold a known level at the pad
            apb(1'b0, adr(pads_pkg::OFF_RD_A, p), 32'h0, 4'hF);
            check(48'(rd[15:0] & dir[p]),
                48'(lvl[p] & ~ana[p] & msk[p] & dir[p]));
            q = $urandom_range(3);
            apb(1'b1, pads_pkg::OFF_VIEW_SEL, 32'(q), 4'hF);
            rdchk(pads_pkg::OFF_VIEW, view(q));
        end
        // the last access ends here, so the bus goes idle
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        summarize();
    end
endmodule : testbench
